// *** rtl/tsi_pkg.sv ***
package tsi_pkg;

    // ****************************************
    // Microport address map
    // ****************************************
    localparam logic [6:0] TSI_ADDR_CONTROL = 7'h00;
    localparam logic [6:0] TSI_ADDR_IMS = 7'h01;
    localparam logic [6:0] TSI_ADDR_FRAME_ALIGN = 7'h02;
    localparam logic [6:0] TSI_ADDR_FIO0 = 7'h03;
    localparam logic [6:0] TSI_ADDR_FIO1 = 7'h04;
    localparam logic [6:0] TSI_ADDR_FIO2 = 7'h05;
    localparam logic [6:0] TSI_ADDR_FIO3 = 7'h06;
    localparam int TSI_TOP_ADDR_BIT = 7;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int TSI_CTRL_SS_LSB = 0;
    localparam int TSI_CTRL_MS_BIT = 4;
    localparam logic [15:0] TSI_CTRL_MASK = 16'h003f;
    localparam int TSI_IMS_RATE_LSB = 0;
    localparam int TSI_IMS_OSB_BIT = 2;
    localparam logic [15:0] TSI_REG_RESET = 16'h0000;
    localparam int TSI_CM_SRC_LSB = 0;
    localparam int TSI_CM_MODE_BIT = 12;
    localparam int TSI_CM_OE_BIT = 13;

    // ****************************************
    // Rates and delay widths
    // ****************************************
    typedef enum logic [1:0] {
        TSI_RATE_2M = 2'b00,
        TSI_RATE_4M = 2'b01,
        TSI_RATE_8M = 2'b10,
        TSI_RATE_RSV = 2'b11
    } tsi_rate_t;
    localparam logic [7:0] TSI_FL_2M = 8'h20;
    localparam logic [7:0] TSI_FL_4M = 8'h40;
    localparam logic [7:0] TSI_FL_8M = 8'h80;
    localparam int TSI_DELAY_W = 9;
    localparam int TSI_MAX_CH = 128;

    // Frame length in time-slots for a rate
    function automatic logic [7:0] tsi_frame_len(input tsi_rate_t rate);
        case (rate)
            TSI_RATE_2M: tsi_frame_len = TSI_FL_2M;
            TSI_RATE_4M: tsi_frame_len = TSI_FL_4M;
            default: tsi_frame_len = TSI_FL_8M;
        endcase
    endfunction : tsi_frame_len

endpackage : tsi_pkg

// *** rtl/tsi_delay_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface tsi_delay_if;
    import tsi_pkg::*;
    tsi_rate_t rate;
    logic mode;
    logic [6:0] out_ch;
    logic [6:0] in_ch;
    logic [TSI_DELAY_W-1:0] delay;
    modport req (output rate, output mode, output out_ch, output in_ch, input delay);
    modport calc (input rate, input mode, input out_ch, input in_ch, output delay);
endinterface : tsi_delay_if
`default_nettype wire

// *** rtl/tsi_delay_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsi_delay_calc (
    // Delay query
    tsi_delay_if.calc dq
);
    import tsi_pkg::*;

    logic [TSI_DELAY_W-1:0] fl;
    logic [TSI_DELAY_W-1:0] m;
    logic [TSI_DELAY_W-1:0] n;

    // Throughput delay arithmetic
    always_comb begin
        fl = {1'b0, tsi_frame_len(dq.rate)};
        m = {2'b00, dq.out_ch};
        n = {2'b00, dq.in_ch};
        if (dq.mode) begin
            dq.delay = fl + (fl - n) + m;
        end else if (m < n) begin
            dq.delay = fl - (n - m);
        end else if (m <= n + 9'h002) begin
            dq.delay = m - n + fl;
        end else begin
            dq.delay = m - n;
        end
    end

endmodule : tsi_delay_calc
`default_nettype wire

// *** rtl/tsi_switch_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsi_switch_ctrl #(
    parameter int STREAMS = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Microport
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // Serial timing and receive data
    input wire logic i_slot_tick,
    input wire logic i_rx_valid,
    input wire logic [3:0] i_rx_stream,
    input wire logic [7:0] i_rx_data,
    // Output control
    input wire logic i_drive_enable_pin,
    output logic [STREAMS-1:0] o_tx_oe,
    output logic [tsi_pkg::TSI_DELAY_W-1:0] o_delay,
    output logic [6:0] o_slot
);
    import tsi_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [15:0] control;
        logic [15:0] interface_mode_select;
        logic [3:0][15:0] fio;
        logic [6:0] slot;
        logic [15:0] rdata;
        logic rvalid;
        logic [TSI_DELAY_W-1:0] delay;
        logic [STREAMS-1:0] tx_oe;
    } tsi_state_t;

    tsi_state_t st_reg;
    tsi_state_t st_next;
    logic [15:0] cmem [STREAMS*TSI_MAX_CH];
    logic [7:0] dmem [STREAMS*TSI_MAX_CH];
    logic [3:0] stream_select;
    logic memory_select_bit;
    logic output_standby_bit;
    tsi_rate_t rate;
    logic [7:0] fl;
    logic [6:0] last_ch;
    logic top_address_bit;
    logic ch_ok;
    logic [10:0] mem_idx;
    logic [10:0] slot_idx;
    logic [10:0] rx_idx;
    logic cm_wr;
    logic [STREAMS-1:0] oe_now;
    logic [15:0] sel_cm;
    tsi_delay_if dq ();

    if (STREAMS < 1 || STREAMS > 16) begin : g_bad_streams
        $error("STREAMS must lie in 1 to 16");
    end

    // ****************************************
    // Decode
    // ****************************************
    // field extraction
    assign stream_select = st_reg.control[TSI_CTRL_SS_LSB +: 4];
    assign memory_select_bit = st_reg.control[TSI_CTRL_MS_BIT];
    assign output_standby_bit = st_reg.interface_mode_select[TSI_IMS_OSB_BIT];
    assign rate = tsi_rate_t'(st_reg.interface_mode_select[TSI_IMS_RATE_LSB +: 2]);
    assign fl = tsi_frame_len(rate);
    assign last_ch = 7'(fl - 8'h01);
    assign top_address_bit = i_addr[TSI_TOP_ADDR_BIT];
    assign ch_ok = i_addr[6:0] <= last_ch;
    assign mem_idx = {stream_select, i_addr[6:0]};
    assign slot_idx = {stream_select, st_reg.slot};
    assign rx_idx = {i_rx_stream, st_reg.slot};
    assign cm_wr = i_cs && i_wr && top_address_bit && ch_ok
        && (int'(stream_select) < STREAMS);
    assign sel_cm = cmem[slot_idx];

    // ****************************************
    // Memories
    // ****************************************
    // no reset of connection memory
    always_ff @(posedge i_clock) begin
        if (cm_wr) begin
            cmem[mem_idx] <= i_wdata;
        end
        if (i_rx_valid && int'(i_rx_stream) < STREAMS) begin
            dmem[rx_idx] <= i_rx_data;
        end
    end

    // Per-stream driver enables
    for (genvar s = 0; s < STREAMS; s++) begin : g_oe
        logic [15:0] cw;
        assign cw = cmem[{4'(s), st_reg.slot}];
        assign oe_now[s] = cw[TSI_CM_OE_BIT] && (i_drive_enable_pin || output_standby_bit);
    end

    // Delay query for the selected stream
    // mode bit to arithmetic
    assign dq.rate = rate;
    assign dq.mode = sel_cm[TSI_CM_MODE_BIT];
    assign dq.out_ch = st_reg.slot;
    assign dq.in_ch = sel_cm[TSI_CM_SRC_LSB +: 7];

    tsi_delay_calc u_calc (
        .dq(dq)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.tx_oe = oe_now;
        st_next.delay = dq.delay;
        if (i_slot_tick) begin
            st_next.slot = (st_reg.slot >= last_ch) ? 7'h00 : st_reg.slot + 7'h01;
        end
        // Register writes
        if (i_cs && i_wr && !top_address_bit) begin
            case (i_addr[6:0])
                TSI_ADDR_CONTROL: st_next.control = i_wdata & TSI_CTRL_MASK;
                TSI_ADDR_IMS: st_next.interface_mode_select = i_wdata;
                TSI_ADDR_FIO0, TSI_ADDR_FIO1, TSI_ADDR_FIO2, TSI_ADDR_FIO3:
                    st_next.fio[2'(i_addr[6:0] - TSI_ADDR_FIO0)] = i_wdata;
                default: st_next.control = st_reg.control;
            endcase
        end
        // Reads
        if (i_cs && i_rd) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = 16'h0000;
            if (top_address_bit) begin
                if (ch_ok && int'(stream_select) < STREAMS) begin
                    st_next.rdata = memory_select_bit ? {8'h00, dmem[mem_idx]} : cmem[mem_idx];
                end
            end else begin
                case (i_addr[6:0])
                    TSI_ADDR_CONTROL: st_next.rdata = st_reg.control;
                    TSI_ADDR_IMS: st_next.rdata = st_reg.interface_mode_select;
                    TSI_ADDR_FRAME_ALIGN: st_next.rdata = {9'h000, st_reg.slot};
                    TSI_ADDR_FIO0, TSI_ADDR_FIO1, TSI_ADDR_FIO2, TSI_ADDR_FIO3:
                        st_next.rdata = st_reg.fio[2'(i_addr[6:0] - TSI_ADDR_FIO0)];
                    default: st_next.rdata = 16'h0000;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_rvalid = st_reg.rvalid;
    assign o_tx_oe = st_reg.tx_oe;
    assign o_delay = st_reg.delay;
    assign o_slot = st_reg.slot;

    // ****************************************
    // Checks
    // ****************************************
    // Full frame length at delay width
    logic [8:0] flx;
    assign flx = {1'b0, fl};

    // Delay arithmetic
    low_out_delay_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (!dq.mode && dq.out_ch < dq.in_ch)
        |=> o_delay == $past(flx) - 9'($past(dq.in_ch) - $past(dq.out_ch)))
        else $error("variable delay for lower output wrong");
    near_out_delay_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (!dq.mode && dq.out_ch >= dq.in_ch && {2'b00, dq.out_ch} <= {2'b00, dq.in_ch} + 9'h002)
        |=> o_delay == 9'($past(dq.out_ch) - $past(dq.in_ch)) + $past(flx))
        else $error("variable delay near output wrong");
    far_out_delay_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (!dq.mode && {2'b00, dq.out_ch} > {2'b00, dq.in_ch} + 9'h002)
        |=> o_delay == 9'($past(dq.out_ch) - $past(dq.in_ch)))
        else $error("same frame delay wrong");
    const_delay_a: assert property (@(posedge i_clock) disable iff (i_srst)
        dq.mode |=> o_delay == 9'($past(flx) + $past(flx) - $past(dq.in_ch) + $past(dq.out_ch)))
        else $error("constant delay wrong");
    // Map, driver and slot wrap checks
    reg_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_wr && !i_addr[7] && i_addr[6:0] == TSI_ADDR_IMS) |=> st_reg.interface_mode_select == $past(i_wdata))
        else $error("register write lost");
    far_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && !i_addr[7] && i_addr[6:0] == TSI_ADDR_FRAME_ALIGN)
        ##1 o_rvalid |-> o_rdata == {9'h000, $past(st_reg.slot)})
        else $error("frame alignment read wrong");
    bad_chan_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && i_addr[7] && !ch_ok) |=> o_rvalid && o_rdata == 16'h0000)
        else $error("out of range channel read not zero");
    oe_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !sel_cm[TSI_CM_OE_BIT] && int'(stream_select) < STREAMS
        |=> !o_tx_oe[$past(stream_select)])
        else $error("disabled channel driven");
    oe_standby_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (!i_drive_enable_pin && !output_standby_bit) |=> o_tx_oe == '0)
        else $error("output driven while pin and standby low");
    slot_wrap_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_slot_tick && st_reg.slot >= last_ch) |=> o_slot == 7'h00)
        else $error("slot counter did not wrap at frame");

    // Register bus answers
    read_answer_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd) |=> o_rvalid)
        else $error("read not answered next cycle");
    read_quiet_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !(i_cs && i_rd) |=> !o_rvalid)
        else $error("read valid without a read");
    ctrl_mask_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_wr && !i_addr[7] && i_addr[6:0] == TSI_ADDR_CONTROL)
        |=> st_reg.control == ($past(i_wdata) & TSI_CTRL_MASK))
        else $error("control write not masked");
    ctrl_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && !i_addr[7] && i_addr[6:0] == TSI_ADDR_CONTROL)
        |=> o_rdata == $past(st_reg.control))
        else $error("control read wrong");
    align_ro_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_wr && !i_addr[7] && i_addr[6:0] == TSI_ADDR_FRAME_ALIGN)
        |=> $stable(st_reg.control) && $stable(st_reg.interface_mode_select) && $stable(st_reg.fio))
        else $error("frame alignment write changed a register");

    // Memory access
    cm_write_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_wr && i_addr[7] && ch_ok && int'(stream_select) < STREAMS)
        |=> cmem[$past(mem_idx)] == $past(i_wdata))
        else $error("connection memory write lost");
    cm_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && i_addr[7] && ch_ok && !memory_select_bit
            && int'(stream_select) < STREAMS)
        |=> o_rdata == $past(cmem[mem_idx]))
        else $error("connection memory read wrong");
    dm_read_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_cs && i_rd && i_addr[7] && ch_ok && memory_select_bit
            && int'(stream_select) < STREAMS)
        |=> o_rdata == {8'h00, $past(dmem[mem_idx])})
        else $error("data memory read wrong");

    // Slot counter and reset
    slot_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
        !i_slot_tick |=> o_slot == $past(st_reg.slot))
        else $error("slot moved without a tick");
    slot_step_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_slot_tick && st_reg.slot < last_ch) |=> o_slot == $past(st_reg.slot) + 7'h01)
        else $error("slot did not advance on tick");
    reset_state_a: assert property (@(posedge i_clock)
        i_srst |=> o_slot == 7'h00 && !o_rvalid && o_tx_oe == '0)
        else $error("outputs not cleared by reset");

    // Driver enables and delay mode
    oe_on_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (sel_cm[TSI_CM_OE_BIT] && (i_drive_enable_pin || output_standby_bit)
            && int'(stream_select) < STREAMS) |=> o_tx_oe[$past(stream_select)])
        else $error("enabled channel not driven");
    mode_const_a: assert property (@(posedge i_clock) disable iff (i_srst)
        dq.mode |=> o_delay >= $past(flx))
        else $error("constant delay below one frame");

endmodule : tsi_switch_ctrl
`default_nettype wire

// *** tb/tsi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host on the microport
// ****************
module tsi_host_model (
    // Clock
    input wire logic i_clock,
    // Microport and drive pin
    output logic o_cs,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [15:0] o_wdata,
    output logic o_drive_enable_pin
);
    initial begin
        o_cs = 1'b0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 16'h0000;
        o_drive_enable_pin = 1'b0;
    end
    task access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        o_cs <= 1'b1;
        o_rd <= ~w;
        o_wr <= w;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        o_cs <= 1'b0;
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        o_addr <= ~a; // Released lines lose old value
        o_wdata <= ~d;
    endtask : access
    task set_pin(input logic v);
        @(posedge i_clock);
        o_drive_enable_pin <= v;
    endtask : set_pin
endmodule : tsi_host_model
`default_nettype wire

// *** tb/tsi_map_delay_output_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module tsi_map_delay_output_control_bench;
    import tsi_pkg::*;
    logic i_clock, i_srst, cs, rd, wr, pin, tick, rx_valid, rvalid;
    logic [7:0] addr, rx_data;
    logic [3:0] rx_stream;
    logic [15:0] wdata, rdata, tx_oe, word;
    logic [8:0] delay;
    logic [6:0] slot;
    logic [31:0] seed = 32'h15;
    logic [31:0] v;
    logic [15:0] expq[$];
    logic md[128], oe[128];
    int nsrc[128];
    int err_total = 0;
    int compares = 0;
    int r, m, n, fl, k;
    tsi_host_model host (.i_clock(i_clock), .o_cs(cs), .o_rd(rd), .o_wr(wr), .o_addr(addr),
        .o_wdata(wdata), .o_drive_enable_pin(pin));
    tsi_switch_ctrl dut (.i_clock(i_clock), .i_srst(i_srst), .i_cs(cs), .i_rd(rd), .i_wr(wr),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_slot_tick(tick), .i_rx_valid(rx_valid), .i_rx_stream(rx_stream),
        .i_rx_data(rx_data), .i_drive_enable_pin(pin), .o_tx_oe(tx_oe),
        .o_delay(delay), .o_slot(slot));
    // Clock and watchdog
    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    initial begin
        repeat (100000) @(posedge i_clock);
        err_total++;
        test_done();
    end
    // Xorshift source
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nxt
    function automatic logic [8:0] exp_dly(int f, int a, int b, logic c);
        if (c) return 9'(2 * f - b + a);
        if (a < b) return 9'(f - (b - a));
        if (a <= b + 2) return 9'(a - b + f);
        return 9'(a - b);
    endfunction : exp_dly
    // Compare and count
    task chk(input string name, input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask : chk
    task reg_wr(input logic [7:0] a, input logic [15:0] d);
        host.access(1'b1, a, d);
    endtask : reg_wr
    task reg_rd(input logic [7:0] a, input logic [15:0] want);
        expq.push_back(want);
        host.access(1'b0, a, 16'h0000);
    endtask : reg_rd
    task test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Read answer monitor
    always @(negedge i_clock) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) chk("read count", 16'h0001, 16'h0000);
            else chk("read data", rdata, expq.pop_front());
        end
    end
    // Main sequence
    initial begin
        i_srst = 1'b1;
        tick = 1'b0;
        rx_valid = 1'b0;
        rx_stream = 4'h0;
        rx_data = 8'h00;
        repeat (8) @(posedge i_clock);
        i_srst <= 1'b0;
        reg_rd(8'h00, 16'h0000);
        reg_rd(8'h01, 16'h0000);
        reg_rd(8'h07, 16'h0000);
        reg_wr(8'h02, 16'h1234);
        reg_rd(8'h02, 16'h0000);
        reg_wr(8'h00, 16'hffff);
        reg_rd(8'h00, 16'h003f);
        for (k = 3; k < 7; k++) begin
            v = nxt();
            reg_wr(8'(k), v[15:0]);
            reg_rd(8'(k), v[15:0]);
        end
        reg_wr(8'h00, 16'h0000);
        for (r = 0; r < 3; r++) begin
            fl = 32 << r;
            host.set_pin(1'b0);
            reg_wr(8'h01, {13'h0000, r[0], r[1:0]});
            for (m = 0; m < fl; m++) begin
                v = nxt();
                case (m % 5)
                    0: n = m;
                    1: n = (m + fl - 2) % fl;
                    2: n = (m + fl - 3) % fl;
                    3: n = (m + 1) % fl;
                    default: n = int'(v[6:0]) % fl;
                endcase
                nsrc[m] = n;
                md[m] = v[8];
                oe[m] = v[9];
                word = {2'b00, v[9], v[8], 5'h00, 7'(n)};
                reg_wr({1'b1, 7'(m)}, word);
            end
            reg_rd({1'b1, 7'(fl - 1)}, word);
            if (r == 0) begin
                reg_wr(8'ha8, 16'h2005);
                reg_rd(8'ha8, 16'h0000);
            end
            // data memory byte at slot 0
            @(posedge i_clock);
            rx_valid <= 1'b1;
            rx_data <= v[23:16];
            @(posedge i_clock);
            rx_valid <= 1'b0;
            reg_wr(8'h00, 16'h0010);
            reg_rd(8'h80, {8'h00, rx_data});
            reg_wr(8'h00, 16'h0000);
            // Walk every slot with random pin
            for (m = 0; m < fl; m++) begin
                v = nxt();
                host.set_pin(v[0]);
                repeat (2) @(posedge i_clock);
                @(negedge i_clock);
                chk("slot", 16'(slot), 16'(m));
                chk("delay", 16'(delay), 16'(exp_dly(fl, m, nsrc[m], md[m])));
                chk("tx enable", 16'(tx_oe[0]), 16'(oe[m] & (v[0] | r[0])));
                if (!(v[0] | r[0])) chk("tx enable all", tx_oe, 16'h0000);
                @(posedge i_clock);
                tick <= 1'b1;
                @(posedge i_clock);
                tick <= 1'b0;
            end
            reg_rd(8'h02, 16'h0000);
        end
        for (k = 0; k < 20 && expq.size() != 0; k++) @(posedge i_clock);
        if (expq.size() != 0) err_total++;
        test_done();
    end
endmodule : tsi_map_delay_output_control_bench
`default_nettype wire
